// File: core/aaddl_defs.vh
// aaddl_defs.vh: constants for the accumulator add and AND datapath.
// assumes inclusion by bare name from the datapath modules.
// Behaviour
// - add-with-carry sums accumulator, memory word and carry into accumulator
// - add-with-carry sets overflow and carry; saturation follows overflow mode
// - direct offset is 0..127 in page; next pointer index is 0..7
// - long immediate add shifts 16-bit constant, signed only in sign-extension mode
// - long immediate AND clears bits outside the shifted constant
// - long immediate AND always clears accumulator bit 31
// - long immediate AND combines bits 30..0 with shifted constant
// - memory AND ands low 16 accumulator bits with memory word
// - memory AND zeroes bits 31..16, independent of sign-extension mode
// - memory operand of add and variable-shift add sign-extended when mode set, else zero-extended
`ifndef AADDL_DEFS_VH
`define AADDL_DEFS_VH
`define AADDL_OP_ADD 4'h0
`define AADDL_OP_ADD_WITH_CARRY 4'h1
`define AADDL_OP_ADD_TO_HIGH_HALF 4'h2
`define AADDL_OP_ADD_NO_SIGN_EXTEND 4'h3
`define AADDL_OP_ADD_VARIABLE_SHIFT 4'h4
`define AADDL_OP_ADD_SHORT_IMMEDIATE 4'h5
`define AADDL_OP_ADD_LONG_IMMEDIATE 4'h6
`define AADDL_OP_ADD_TO_POINTER_IMMEDIATE 4'h7
`define AADDL_OP_AND 4'h8
`define AADDL_OP_AND_LONG_IMMEDIATE 4'h9
`define AADDL_A_CTRL 4'h0
`define AADDL_A_OPND 4'h4
`define AADDL_A_ACC 4'h8
`define AADDL_A_STAT 4'hc
`define AADDL_A_IRQ 5'h10
`define AADDL_A_MASK 5'h14
`define AADDL_A_PTR 5'h18
`define AADDL_A_TREG 5'h1c
`define AADDL_DMA_MAX 7'h7f
`define AADDL_ARP_MAX 3'h7
`define AADDL_SAT_POS 32'h7fffffff
`define AADDL_SAT_NEG 32'h80000000
`define AADDL_IRQ_DONE 0
`define AADDL_IRQ_OVF 1
`define AADDL_IRQ_CARRY 2
`endif

// File: core/aaddl_ptr_file.v
// aaddl_ptr_file.v: eight 16-bit index pointers with registered read.
// assumes one writer on the block clock.
`timescale 1ns/10ps
`include "aaddl_defs.vh"
module aaddl_ptr_file (
  clk,
  rst_n,
  we,
  waddr,
  wdata,
  raddr,
  rdata
);
  input wire clk;
  input wire rst_n;
  input wire we;
  input wire [2:0] waddr;
  input wire [15:0] wdata;
  input wire [2:0] raddr;
  output reg [15:0] rdata;
  reg [15:0] mem [0:7];
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_ent
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          mem[g] <= 16'h0000;
        else if (we && waddr == g)
          mem[g] <= wdata;
      end
    end
  endgenerate
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rdata <= 16'h0000;
    else
      rdata <= mem[raddr];
  end
endmodule

// File: core/aaddl_alu.v
// aaddl_alu.v: combinational adder and AND unit for the accumulator.
// assumes operands are stable for the cycle they are applied.
`timescale 1ns/10ps
`include "aaddl_defs.vh"
module aaddl_alu (
  op,
  acc,
  mem_word,
  imm,
  shift,
  treg_low,
  carry_in,
  sign_extension_mode,
  overflow_saturate_mode,
  result,
  carry_out,
  ovf,
  upd_carry,
  upd_ovf
);
  input wire [3:0] op;
  input wire [31:0] acc;
  input wire [15:0] mem_word;
  input wire [15:0] imm;
  input wire [3:0] shift;
  input wire [3:0] treg_low;
  input wire carry_in;
  input wire sign_extension_mode;
  input wire overflow_saturate_mode;
  output reg [31:0] result;
  output reg carry_out;
  output reg ovf;
  output reg upd_carry;
  output reg upd_ovf;
  reg [31:0] ext;
  reg [31:0] opnd;
  reg [32:0] sum;
  reg cin;
  always @* begin
    ext = sign_extension_mode ? {{16{mem_word[15]}}, mem_word} : {16'h0000, mem_word};
    opnd = 32'h00000000;
    cin = 1'b0;
    upd_carry = 1'b1;
    upd_ovf = 1'b1;
    case (op)
      `AADDL_OP_ADD: opnd = ext << shift;
      `AADDL_OP_ADD_VARIABLE_SHIFT: opnd = ext << treg_low;
      `AADDL_OP_ADD_WITH_CARRY: begin
        opnd = {16'h0000, mem_word};
        cin = carry_in;
      end
      `AADDL_OP_ADD_TO_HIGH_HALF: begin
        opnd = {mem_word, 16'h0000};
        // upper-half add never raises the overflow flag or its event
        upd_ovf = 1'b0;
      end
      `AADDL_OP_ADD_NO_SIGN_EXTEND: opnd = {16'h0000, mem_word};
      `AADDL_OP_ADD_SHORT_IMMEDIATE: opnd = {24'h000000, imm[7:0]};
      `AADDL_OP_ADD_LONG_IMMEDIATE: opnd = (sign_extension_mode ? {{16{imm[15]}}, imm} : {16'h0000, imm}) << shift;
      default: begin
        upd_carry = 1'b0;
        upd_ovf = 1'b0;
      end
    endcase
    sum = {1'b0, acc} + {1'b0, opnd} + {32'h00000000, cin};
    ovf = (acc[31] == opnd[31]) && (sum[31] != acc[31]);
    carry_out = sum[32];
    result = sum[31:0];
    if (op == `AADDL_OP_ADD_TO_HIGH_HALF && !sum[32])
      carry_out = carry_in;
    if (ovf && overflow_saturate_mode)
      result = acc[31] ? `AADDL_SAT_NEG : `AADDL_SAT_POS;
    if (op == `AADDL_OP_AND)
      result = {16'h0000, acc[15:0] & mem_word};
    if (op == `AADDL_OP_AND_LONG_IMMEDIATE)
      result = acc & ({16'h0000, imm} << shift) & `AADDL_SAT_POS;
  end
endmodule

// File: core/aaddl_top.v
// aaddl_top.v: accumulator add/AND execution unit with Wishbone registers.
// assumes a classic Wishbone master on clk; the decoder writes opcodes via CTRL.
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/10ps
`include "aaddl_defs.vh"
module aaddl_top (
  clk,
  rst_n,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_sel_i,
  wb_dat_i,
  wb_dat_o,
  wb_ack_o,
  irq
);
  input wire clk;
  input wire rst_n;
  input wire wb_cyc_i;
  input wire wb_stb_i;
  input wire wb_we_i;
  input wire [7:0] wb_adr_i;
  input wire [3:0] wb_sel_i;
  input wire [31:0] wb_dat_i;
  output reg [31:0] wb_dat_o;
  output reg wb_ack_o;
  output reg irq;
  localparam S_IDLE = 3'b001;
  localparam S_FETCH = 3'b010;
  localparam S_EXEC = 3'b100;
  reg [2:0] state;
  reg [3:0] op;
  reg [3:0] shift;
  reg [6:0] dma;
  reg [2:0] pointer_select_index;
  reg [15:0] mem_word;
  reg [15:0] imm;
  reg [15:0] treg;
  reg [31:0] acc;
  reg carry;
  reg overflow_flag;
  reg sign_extension_mode;
  reg overflow_saturate_mode;
  reg [2:0] irq_stat;
  reg [2:0] irq_mask;
  wire [31:0] alu_res;
  wire alu_c;
  wire alu_v;
  wire upd_c;
  wire upd_v;
  wire [15:0] ptr_rd;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = req && wb_we_i && wb_sel_i[0];
  wire start = wr && wb_adr_i == {4'h0, `AADDL_A_CTRL} && state == S_IDLE;
  wire ptr_we = state == S_EXEC && op == `AADDL_OP_ADD_TO_POINTER_IMMEDIATE;
  wire [15:0] ptr_sum = ptr_rd + {8'h00, imm[7:0]};
  wire [2:0] ev;
  assign ev[`AADDL_IRQ_DONE] = state == S_EXEC;
  assign ev[`AADDL_IRQ_OVF] = state == S_EXEC && upd_v && alu_v;
  assign ev[`AADDL_IRQ_CARRY] = state == S_EXEC && upd_c && alu_c;
  aaddl_alu u_alu (
    .op(op),
    .acc(acc),
    .mem_word(mem_word),
    .imm(imm),
    .shift(shift),
    .treg_low(treg[3:0]),
    .carry_in(carry),
    .sign_extension_mode(sign_extension_mode),
    .overflow_saturate_mode(overflow_saturate_mode),
    .result(alu_res),
    .carry_out(alu_c),
    .ovf(alu_v),
    .upd_carry(upd_c),
    .upd_ovf(upd_v)
  );
  aaddl_ptr_file u_ptr (
    .clk(clk),
    .rst_n(rst_n),
    .we(ptr_we),
    .waddr(pointer_select_index),
    .wdata(ptr_sum),
    .raddr(pointer_select_index),
    .rdata(ptr_rd)
  );
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      op <= 4'h0;
      shift <= 4'h0;
      dma <= 7'h00;
      pointer_select_index <= 3'h0;
      mem_word <= 16'h0000;
      imm <= 16'h0000;
      treg <= 16'h0000;
      acc <= 32'h00000000;
      carry <= 1'b0;
      overflow_flag <= 1'b0;
      sign_extension_mode <= 1'b0;
      overflow_saturate_mode <= 1'b0;
      irq_mask <= 3'h0;
    end else begin
      case (state)
        S_IDLE: if (start) state <= S_FETCH;
        S_FETCH: state <= S_EXEC;
        S_EXEC: begin
          state <= S_IDLE;
          if (op != `AADDL_OP_ADD_TO_POINTER_IMMEDIATE)
            acc <= alu_res;
          if (upd_c)
            carry <= alu_c;
          if (upd_v && alu_v && op != `AADDL_OP_ADD_TO_HIGH_HALF)
            overflow_flag <= 1'b1;
        end
        default: state <= S_IDLE;
      endcase
      if (wr && wb_adr_i == {4'h0, `AADDL_A_CTRL} && state == S_IDLE) begin
        op <= wb_dat_i[3:0];
        shift <= wb_dat_i[7:4];
        dma <= wb_dat_i[14:8] & `AADDL_DMA_MAX;
        pointer_select_index <= wb_dat_i[18:16] & `AADDL_ARP_MAX;
      end else if (wr && wb_adr_i == {4'h0, `AADDL_A_OPND} && state == S_IDLE) begin
        mem_word <= wb_dat_i[15:0];
        imm <= wb_dat_i[31:16];
      end else if (wr && wb_adr_i == {4'h0, `AADDL_A_ACC} && state == S_IDLE) begin
        acc <= wb_dat_i;
      end else if (wr && wb_adr_i == {4'h0, `AADDL_A_STAT} && state == S_IDLE) begin
        carry <= wb_dat_i[0];
        overflow_flag <= wb_dat_i[1];
        sign_extension_mode <= wb_dat_i[2];
        overflow_saturate_mode <= wb_dat_i[3];
      end else if (wr && wb_adr_i == {3'h0, `AADDL_A_MASK}) begin
        irq_mask <= wb_dat_i[2:0];
      end else if (wr && wb_adr_i == {3'h0, `AADDL_A_TREG}) begin
        treg <= wb_dat_i[15:0];
      end
    end
  end
  // set wins over write-one-to-clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      irq_stat <= 3'h0;
    else if (wr && wb_adr_i == {3'h0, `AADDL_A_IRQ})
      irq_stat <= (irq_stat & ~wb_dat_i[2:0]) | ev;
    else
      irq_stat <= irq_stat | ev;
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_mask);
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h00000000;
      if (req && !wb_we_i) begin
        if (wb_adr_i == {4'h0, `AADDL_A_CTRL})
          wb_dat_o <= {13'h0000, pointer_select_index, 1'b0, dma, shift, op};
        else if (wb_adr_i == {4'h0, `AADDL_A_OPND})
          wb_dat_o <= {imm, mem_word};
        else if (wb_adr_i == {4'h0, `AADDL_A_ACC})
          wb_dat_o <= acc;
        else if (wb_adr_i == {4'h0, `AADDL_A_STAT})
          wb_dat_o <= {27'h0000000, state != S_IDLE, overflow_saturate_mode, sign_extension_mode,
                       overflow_flag, carry};
        else if (wb_adr_i == {3'h0, `AADDL_A_IRQ})
          wb_dat_o <= {29'h00000000, irq_stat};
        else if (wb_adr_i == {3'h0, `AADDL_A_MASK})
          wb_dat_o <= {29'h00000000, irq_mask};
        else if (wb_adr_i == {3'h0, `AADDL_A_PTR})
          wb_dat_o <= {16'h0000, ptr_rd};
        else if (wb_adr_i == {3'h0, `AADDL_A_TREG})
          wb_dat_o <= {16'h0000, treg};
      end
    end
  end
endmodule

// File: test/aaddl_top_props.sv
// aaddl_top_props.sv: bus and result checks on the ports of aaddl_top.
// assumes one clock and a classic Wishbone master at the ports.
`timescale 1ns/10ps
module aaddl_top_props (
  input wire clk,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] last_op;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire acc_rd = req && !wb_we_i && wb_adr_i == 8'h08;
  // an accumulator write makes the last opcode stale
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      last_op <= 4'h0;
    else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00)
      last_op <= wb_dat_i[3:0];
    else if (req && wb_we_i && wb_adr_i == 8'h08)
      last_op <= 4'h0;
  sequence s_req;
    req;
  endsequence
  sequence s_mask_off;
    req && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h14 && wb_dat_i[2:0] == 3'h0;
  endsequence
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  chk_ack_answer: assert property (s_req |=> wb_ack_o) else $error("request not answered");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  chk_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i >= 8'h20 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_stat_reserved: assert property (req && !wb_we_i && wb_adr_i == 8'h0c |=> wb_dat_o[31:5] == 27'h0)
    else $error("status upper bits set");
  chk_irq_masked: assert property (s_mask_off |=> ##1 !irq) else $error("irq while fully masked");
  chk_and_long_immediate_top: assert property (acc_rd && last_op == 4'h9 |=> !wb_dat_o[31])
    else $error("bit 31 kept after long and");
  chk_and_upper: assert property (acc_rd && last_op == 4'h8 |=> wb_dat_o[31:16] == 16'h0)
    else $error("upper half kept after memory and");
endmodule
bind aaddl_top aaddl_top_props i_props (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq(irq));

// File: test/aaddl_dec_model.sv
// aaddl_dec_model.sv: decoder and memory side, a classic Wishbone master.
// assumes the block acks every request; the bench watchdog ends a hang.
`timescale 1ns/10ps
module aaddl_dec_model (
  input wire clk,
  input wire ack,
  input wire [31:0] rdat,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] wdat
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    // released data flips so a stale value is never mistaken for valid
    wdat <= ~d;
  endtask
endmodule

// File: test/aaddl_top_test.sv
// aaddl_top_test.sv: register-level tests of the accumulator add and and unit.
// assumes the decoder model drives the bus; ops are issued through the registers.
`timescale 1ns/10ps
`include "aaddl_defs.vh"
module aaddl_top_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire cyc, stb, we, ack, irq;
  wire [7:0] adr;
  wire [3:0] sel;
  wire [31:0] wdat, rdat;
  int errors = 0;
  int num_checks = 0;
  aaddl_top i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq));
  aaddl_dec_model i_dec (.clk(clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .wdat(wdat));
  initial forever #2.5 clk = ~clk;
  task finish_test;
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_dec.xfer(1'b1, a, d, q);
  endtask
  task rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_dec.xfer(1'b0, a, 32'h0, q);
    chk(n, e, q);
  endtask
  // status, start acc, ctrl, operand word, expected acc
  task op(input logic [31:0] st, acc, ctl, opnd, e);
    wr(`AADDL_A_STAT, st);
    wr(`AADDL_A_ACC, acc);
    wr(`AADDL_A_OPND, opnd);
    wr(`AADDL_A_CTRL, ctl);
    repeat (4) @(posedge clk);
    rd("acc", `AADDL_A_ACC, e);
  endtask
  initial begin
    #20000;
    errors = errors + 1;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd("stat", `AADDL_A_STAT, 32'h0);
    rd("acc", `AADDL_A_ACC, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    op(32'h4, 32'h10, 32'h7f40, 32'h8000, 32'hfff80010);
    op(32'h0, 32'h10, 32'h7f40, 32'h8000, 32'h00080010);
    op(32'h1, 32'hffffffff, 32'h1, 32'h1, 32'h1);
    rd("stat", `AADDL_A_STAT, 32'h1);
    op(32'h8, 32'h7fffffff, 32'h1, 32'h1, 32'h7fffffff);
    rd("stat", `AADDL_A_STAT, 32'ha);
    op(32'h0, 32'h1234, 32'h2, 32'h1, 32'h11234);
    op(32'h4, 32'h0, 32'h3, 32'h8000, 32'h8000);
    wr(`AADDL_A_TREG, 32'h3);
    op(32'h4, 32'h0, 32'hf4, 32'h1, 32'h8);
    op(32'h4, 32'h0, 32'h5, 32'h00ff0000, 32'hff);
    op(32'h4, 32'h0, 32'h6, 32'h80000000, 32'hffff8000);
    op(32'h0, 32'h0, 32'h46, 32'h80000000, 32'h80000);
    op(32'h0, 32'hffffffff, 32'hf9, 32'hffff0000, 32'h7fff8000);
    op(32'h4, 32'hffffffff, 32'h9, 32'h00f00000, 32'hf0);
    op(32'h4, 32'hffffffff, 32'h8, 32'h1234, 32'h1234);
    op(32'h0, 32'h0, 32'h77f07, 32'h00800000, 32'h0);
    rd("ptr", `AADDL_A_PTR, 32'h80);
    rd("ctrl", `AADDL_A_CTRL, 32'h00077f07);
    wr(`AADDL_A_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`AADDL_A_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    // done, overflow and carry events have all occurred by now
    rd("irq_status", `AADDL_A_IRQ, 32'h7);
    wr(`AADDL_A_IRQ, 32'h7);
    rd("irq_status", `AADDL_A_IRQ, 32'h0);
    wr(`AADDL_A_MASK, 32'h7);
    op(32'h0, 32'h0, 32'h5, 32'h00010000, 32'h1);
    rd("irq_status", `AADDL_A_IRQ, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    rd("unmapped", 8'h40, 32'h0);
    finish_test;
  end
endmodule
